// [dhspc_pkg.sv]
package dhspc_pkg;
    localparam int NUM_DRIVES = 2;
    localparam int CLK_HZ = 50000000;
    // over-current blanking each time a rail is enabled, including after a retry
    localparam int BLANK_NS = 640;
    localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // retry interval and start stagger, one third of a second
    localparam int RETRY_DEN = 3;
    localparam int RETRY_CYC = CLK_HZ / RETRY_DEN;
    // five volt domain reset hold
    localparam int RST_HOLD_MS = 150;
    localparam int RST_HOLD_CYC = RST_HOLD_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;
    // led blink divider: half period in cycles
    localparam int BLINK_HALF_CYC = CLK_HZ / 4;
    // management bus address range
    localparam logic [6:0] MGMT_ADDR_LO = 7'h10;
    localparam logic [6:0] MGMT_ADDR_HI = 7'h1F;
    localparam logic [7:0] FRU_ADDR = 8'hA0;
    localparam logic [18:0] BOOT_BLOCK_BASE = 19'h70000;
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_YELLOW = 2'h2;
    localparam logic [1:0] LED_RED = 2'h3;
    typedef enum logic [1:0] {
        RAIL_OFF = 2'h0,
        RAIL_BLANK = 2'h1,
        RAIL_ON = 2'h2,
        RAIL_WAIT = 2'h3
    } dhspc_rail_t;
endpackage

// [dhspc_rail.sv]
`timescale 1ns/1ns
module dhspc_rail
    import dhspc_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYC
) (
    input wire logic ref_clk, // system clock
    input wire logic reset, // sync reset
    input wire logic start, // one-cycle start request
    input wire logic stop, // power-off command
    input wire logic overCurrent, // over-current sense
    output logic railEn, // switch enable
    output logic faulted // rail in retry cycle
);
    dhspc_rail_t state_ff;
    logic [CNT_W-1:0] cnt_ff;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff <= RAIL_OFF;
            cnt_ff <= '0;
        end else if (stop) begin
            state_ff <= RAIL_OFF;
            cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                RAIL_OFF: begin
                    if (start) begin
                        state_ff <= RAIL_BLANK;
                        cnt_ff <= '0;
                    end
                end
                RAIL_BLANK: begin
                    // over-current ignored here
                    if (cnt_ff == CNT_W'(BLANK_CYC - 1)) begin
                        state_ff <= RAIL_ON;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
                RAIL_ON: begin
                    if (overCurrent) begin
                        state_ff <= RAIL_WAIT;
                        cnt_ff <= '0;
                    end
                end
                RAIL_WAIT: begin
                    if (cnt_ff == CNT_W'(RETRY_CYCLES - 1)) begin
                        state_ff <= RAIL_BLANK;
                        cnt_ff <= '0;
                    end else begin
                        cnt_ff <= cnt_ff + 1'b1;
                    end
                end
            endcase
        end
    end

    assign railEn = (state_ff == RAIL_BLANK) || (state_ff == RAIL_ON);
    assign faulted = (state_ff == RAIL_WAIT);

    a_blank_ignores_oc: assert property (@(posedge ref_clk) disable iff (reset)
        state_ff == RAIL_BLANK && !stop |=> railEn)
        else $error("rail dropped during blanking");
    a_oc_trips_rail: assert property (@(posedge ref_clk) disable iff (reset)
        state_ff == RAIL_ON && overCurrent && !stop |=> !railEn)
        else $error("over-current did not open rail");
    a_stop_opens: assert property (@(posedge ref_clk) disable iff (reset)
        stop |=> !railEn)
        else $error("stop left rail on");
    c_retry: cover property (@(posedge ref_clk) disable iff (reset)
        state_ff == RAIL_WAIT ##1 state_ff == RAIL_BLANK);
endmodule

// [dhspc_top.sv]
`timescale 1ns/1ns
// Contract
// - each drive's 12 V and 5 V rails switch independently.
// - insertion reported to system; power applied only on system command.
// - power-down command removes both rails of the drive.
// - presence comes from the connector interlock and is reported.
// - over-current on a rail turns off only that rail.
// - tripped rail retries each interval until fault clears or power off.
// - over-current ignored during blanking after rail enable.
// - drives never start together; next start one interval after previous.
// - five volt good only while 5 V rail within tolerance.
// - twelve volt good while 12 V rail above nominal less five percent.
// - drive supply good is AND of five and twelve volt good.
// - controller isolated from management bus until system power good.
// - controller reset only at power-up; five_volt_domain_reset_n also reasserts whenever 5 V leaves tolerance.
// - bi-colour led per drive: green activity, yellow or red fault.
// - drive status reported to server and enclosure management.
// - requests from either bus drive led and power controls.
// - controller answers management bus addresses in fixed range.
// - fru eeprom only on private local bus at fixed address.
// - boot block in top block protected; rest rewritable.
// - controller runs from a single fixed clock.
// - five volt domain reset held low after 5 V returns good.
module dhspc_top
    import dhspc_pkg::*;
#(
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int RST_CYCLES = RST_HOLD_CYC,
    parameter int BLINK_CYCLES = BLINK_HALF_CYC
) (
    input wire logic ref_clk, // 50 MHz single clock
    input wire logic reset, // sync reset, power-up only
    input wire logic [NUM_DRIVES-1:0] interlockMated, // connector interlock closed
    input wire logic [NUM_DRIVES-1:0] cmdPowerOn, // system power-on request pulse
    input wire logic [NUM_DRIVES-1:0] cmdPowerOff, // system power-off request pulse
    input wire logic [NUM_DRIVES-1:0] oc12, // 12 V over-current sense
    input wire logic [NUM_DRIVES-1:0] oc5, // 5 V over-current sense
    input wire logic [NUM_DRIVES-1:0] driveActive, // drive activity
    input wire logic [NUM_DRIVES-1:0] faultBlink, // blink fault colour
    input wire logic [NUM_DRIVES-1:0] faultRed, // red rather than yellow
    input wire logic [NUM_DRIVES-1:0] faultReq, // fault from management
    input wire logic fiveInTol, // 5 V comparator within +/-5%
    input wire logic twelveAboveMin, // 12 V comparator above -5%
    input wire logic system_power_good, // system supply good
    input wire logic [6:0] mgmtAddrStrap, // management bus address strap
    input wire logic [18:0] flashWrAddr, // requested flash write address
    input wire logic flashWrReq, // flash write request from management bus
    input wire logic bootUnlock, // boot block unprotect
    output logic [NUM_DRIVES-1:0] en12, // 12 V switch enable
    output logic [NUM_DRIVES-1:0] en5, // 5 V switch enable
    output logic [NUM_DRIVES-1:0] present, // drive presence
    output logic [NUM_DRIVES-1:0] insertEvent, // insertion notify pulse
    output logic [NUM_DRIVES-1:0] railFault, // rail in retry
    output logic [2*NUM_DRIVES-1:0] ledColour, // 2 bits per drive
    output logic drive_supply_good, // 5 V and 12 V good
    output logic board_power_good, // 5 V good and system good
    output logic five_volt_domain_reset_n, // controller domain reset
    output logic mgmtBusConnect, // management bus isolator enable
    output logic [6:0] mgmtAddr, // answering address
    output logic mgmtAddrOk, // address within range
    output logic [7:0] fruAddr, // local bus fru address
    output logic flashWrEn // flash write permitted
);
    logic [NUM_DRIVES-1:0] present_ff;
    logic [NUM_DRIVES-1:0] insert_ff;
    logic [NUM_DRIVES-1:0] pending_ff;
    logic [NUM_DRIVES-1:0] powered_ff;
    logic [NUM_DRIVES-1:0] startPulse;
    logic [CNT_W-1:0] stagger_ff;
    logic staggerBusy;
    logic [CNT_W-1:0] rstCnt_ff;
    logic rstN_ff;
    logic good_ff;
    logic boardGood_ff;
    logic connect_ff;
    logic [CNT_W-1:0] blinkCnt_ff;
    logic blink_ff;
    logic [2*NUM_DRIVES-1:0] led_ff;
    logic [6:0] addr_ff;
    logic addrOk_ff;
    logic flashEn_ff;
    logic [NUM_DRIVES-1:0] f12;
    logic [NUM_DRIVES-1:0] f5;
    logic [CNT_W-1:0] sinceStart_ff;
    logic startSeen_ff;

    // presence and insertion notify
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            present_ff <= '0;
            insert_ff <= '0;
        end else begin
            present_ff <= interlockMated;
            insert_ff <= interlockMated & ~present_ff;
        end
    end

    // powered/pending bookkeeping; power-on only on command
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pending_ff <= '0;
            powered_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_DRIVES; i++) begin
                if (cmdPowerOff[i] || !present_ff[i]) begin
                    pending_ff[i] <= 1'b0;
                    powered_ff[i] <= 1'b0;
                end else if (startPulse[i]) begin
                    pending_ff[i] <= 1'b0;
                    powered_ff[i] <= 1'b1;
                end else if (cmdPowerOn[i] && !powered_ff[i]) begin
                    pending_ff[i] <= 1'b1;
                end
            end
        end
    end

    // stagger: one start at a time, lowest index first
    assign staggerBusy = (stagger_ff != '0);
    always_comb begin
        startPulse = '0;
        if (!staggerBusy) begin
            for (int i = NUM_DRIVES - 1; i >= 0; i--) begin
                if (pending_ff[i] && !cmdPowerOff[i] && present_ff[i]) begin
                    startPulse = '0;
                    startPulse[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stagger_ff <= '0;
        end else if (startPulse != '0) begin
            stagger_ff <= CNT_W'(RETRY_CYCLES - 1);
        end else if (staggerBusy) begin
            stagger_ff <= stagger_ff - 1'b1;
        end
    end

    // cycles since the last drive start, saturating; lets the full gap be checked
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sinceStart_ff <= '0;
            startSeen_ff <= 1'b0;
        end else if (startPulse != '0) begin
            sinceStart_ff <= '0;
            startSeen_ff <= 1'b1;
        end else if (sinceStart_ff != '1) begin
            sinceStart_ff <= sinceStart_ff + 1'b1;
        end
    end

    // per drive, per rail switch control
    genvar g;
    generate
        for (g = 0; g < NUM_DRIVES; g++) begin : gRail
            logic stopReq;
            assign stopReq = cmdPowerOff[g] || !present_ff[g];
            dhspc_rail #(.RETRY_CYCLES(RETRY_CYCLES)) uR12 (
                .ref_clk(ref_clk),
                .reset(reset),
                .start(startPulse[g]),
                .stop(stopReq),
                .overCurrent(oc12[g]),
                .railEn(en12[g]),
                .faulted(f12[g])
            );
            dhspc_rail #(.RETRY_CYCLES(RETRY_CYCLES)) uR5 (
                .ref_clk(ref_clk),
                .reset(reset),
                .start(startPulse[g]),
                .stop(stopReq),
                .overCurrent(oc5[g]),
                .railEn(en5[g]),
                .faulted(f5[g])
            );
        end
    endgenerate

    // supply good combining
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            good_ff <= 1'b0;
            boardGood_ff <= 1'b0;
        end else begin
            good_ff <= fiveInTol && twelveAboveMin;
            boardGood_ff <= fiveInTol && system_power_good;
        end
    end

    // five volt domain reset hold, restarted whenever 5 V leaves tolerance
    always_ff @(posedge ref_clk) begin
        if (reset || !fiveInTol) begin
            rstCnt_ff <= '0;
            rstN_ff <= 1'b0;
        end else if (rstCnt_ff == CNT_W'(RST_CYCLES - 1)) begin
            rstN_ff <= 1'b1;
        end else begin
            rstCnt_ff <= rstCnt_ff + 1'b1;
        end
    end

    // bus isolation
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            connect_ff <= 1'b0;
        end else begin
            connect_ff <= system_power_good;
        end
    end

    // addresses and flash protection
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            addr_ff <= MGMT_ADDR_LO;
            addrOk_ff <= 1'b0;
            flashEn_ff <= 1'b0;
        end else begin
            addr_ff <= mgmtAddrStrap;
            addrOk_ff <= (mgmtAddrStrap >= MGMT_ADDR_LO)
                && (mgmtAddrStrap <= MGMT_ADDR_HI);
            flashEn_ff <= flashWrReq && connect_ff
                && ((flashWrAddr < BOOT_BLOCK_BASE) || bootUnlock);
        end
    end

    // blink divider
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            blinkCnt_ff <= '0;
            blink_ff <= 1'b0;
        end else if (blinkCnt_ff == CNT_W'(BLINK_CYCLES - 1)) begin
            blinkCnt_ff <= '0;
            blink_ff <= ~blink_ff;
        end else begin
            blinkCnt_ff <= blinkCnt_ff + 1'b1;
        end
    end

    // led colour: fault wins over activity
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            led_ff <= '0;
        end else begin
            for (int i = 0; i < NUM_DRIVES; i++) begin
                if (faultReq[i] || f12[i] || f5[i]) begin
                    led_ff[2*i +: 2] <= (faultBlink[i] && !blink_ff) ? LED_OFF
                        : (faultRed[i] ? LED_RED : LED_YELLOW);
                end else if (driveActive[i] && present_ff[i]) begin
                    led_ff[2*i +: 2] <= LED_GREEN;
                end else begin
                    led_ff[2*i +: 2] <= LED_OFF;
                end
            end
        end
    end

    assign present = present_ff;
    assign insertEvent = insert_ff;
    assign railFault = f12 | f5;
    assign ledColour = led_ff;
    assign drive_supply_good = good_ff;
    assign board_power_good = boardGood_ff;
    assign five_volt_domain_reset_n = rstN_ff;
    assign mgmtBusConnect = connect_ff;
    assign mgmtAddr = addr_ff;
    assign mgmtAddrOk = addrOk_ff;
    assign fruAddr = FRU_ADDR;
    assign flashWrEn = flashEn_ff;

    a_no_dual_start: assert property (@(posedge ref_clk) disable iff (reset)
        $onehot0(startPulse))
        else $error("two drives started together");
    a_stagger_gap: assert property (@(posedge ref_clk) disable iff (reset)
        startPulse != '0 |=> startPulse == '0 [*8])
        else $error("start too soon after previous");
    a_stagger_full: assert property (@(posedge ref_clk) disable iff (reset)
        startPulse != '0 && startSeen_ff |-> sinceStart_ff >= CNT_W'(RETRY_CYCLES - 1))
        else $error("start inside the stagger interval");
    a_good_and: assert property (@(posedge ref_clk) disable iff (reset)
        drive_supply_good == $past(fiveInTol && twelveAboveMin))
        else $error("supply good not the AND");
    a_good_low: assert property (@(posedge ref_clk) disable iff (reset)
        !$past(fiveInTol) |-> !drive_supply_good && !board_power_good)
        else $error("supply good with 5 V out of tolerance");
    a_bus_isolate: assert property (@(posedge ref_clk) disable iff (reset)
        !$past(system_power_good) |-> !mgmtBusConnect)
        else $error("bus connected without power good");
    a_reset_low_tol: assert property (@(posedge ref_clk) disable iff (reset)
        !fiveInTol |=> !five_volt_domain_reset_n)
        else $error("domain reset released out of tolerance");
    a_rst_hold_min: assert property (@(posedge ref_clk) disable iff (reset)
        !fiveInTol |=> !five_volt_domain_reset_n [*8])
        else $error("domain reset released too early");
    a_power_needs_cmd: assert property (@(posedge ref_clk) disable iff (reset)
        startPulse[0] |-> pending_ff[0])
        else $error("drive powered without command");
    a_off_both_rails: assert property (@(posedge ref_clk) disable iff (reset)
        cmdPowerOff[1] |=> !en12[1] && !en5[1])
        else $error("power off left a rail on");
    a_insert_notify: assert property (@(posedge ref_clk) disable iff (reset)
        $rose(present_ff[0]) |-> insertEvent[0])
        else $error("insertion not reported");
    a_present_follow: assert property (@(posedge ref_clk) disable iff (reset)
        present == $past(interlockMated))
        else $error("presence does not follow interlock");
    a_addr_range: assert property (@(posedge ref_clk) disable iff (reset)
        mgmtAddrOk |-> mgmtAddr >= MGMT_ADDR_LO && mgmtAddr <= MGMT_ADDR_HI)
        else $error("address accepted outside range");
    a_flash_protect: assert property (@(posedge ref_clk) disable iff (reset)
        flashWrEn |-> $past(flashWrAddr) < BOOT_BLOCK_BASE || $past(bootUnlock))
        else $error("write allowed into boot block");

    // per drive led, removal and notify checks
    genvar h;
    generate
        for (h = 0; h < NUM_DRIVES; h++) begin : gChk
            a_led_fault: assert property (@(posedge ref_clk) disable iff (reset)
                (faultReq[h] || f12[h] || f5[h]) && !faultBlink[h]
                |=> ledColour[2*h +: 2] == LED_YELLOW || ledColour[2*h +: 2] == LED_RED)
                else $error("fault colour missing");
            a_led_active: assert property (@(posedge ref_clk) disable iff (reset)
                driveActive[h] && present_ff[h] && !faultReq[h] && !f12[h] && !f5[h]
                |=> ledColour[2*h +: 2] == LED_GREEN)
                else $error("activity colour missing");
            a_absent_off: assert property (@(posedge ref_clk) disable iff (reset)
                !present_ff[h] |=> !en12[h] && !en5[h])
                else $error("absent drive left powered");
            a_insert_pulse: assert property (@(posedge ref_clk) disable iff (reset)
                insertEvent[h] |=> !insertEvent[h])
                else $error("insertion notify longer than one cycle");
        end
    endgenerate

    c_both_pending: cover property (@(posedge ref_clk) disable iff (reset)
        pending_ff == '1);
    c_drive_on: cover property (@(posedge ref_clk) disable iff (reset)
        en12[0] && en5[0]);
    c_reset_release: cover property (@(posedge ref_clk) disable iff (reset)
        $rose(five_volt_domain_reset_n));
    c_stagger: cover property (@(posedge ref_clk) disable iff (reset)
        startPulse[0] ##[1:60] startPulse[1]);
endmodule

// [dhspc_sys_model.sv]
`timescale 1ns/1ns
// system side: powers a drive only after hearing of its insertion
module dhspc_sys_model
    import dhspc_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic reset, // sync reset
    input wire logic [NUM_DRIVES-1:0] insertEvent, // insertion notify from device
    input wire logic [NUM_DRIVES-1:0] offReq, // user asks for removal
    input wire logic slowAns, // answer late rather than at once
    output logic [NUM_DRIVES-1:0] cmdPowerOn, // power-on command pulse
    output logic [NUM_DRIVES-1:0] cmdPowerOff // power-off command pulse
);
    logic [NUM_DRIVES-1:0] waitOn;
    logic [3:0] dly [NUM_DRIVES];

    always @(posedge ref_clk) begin
        cmdPowerOn <= '0;
        cmdPowerOff <= reset ? '0 : offReq;
        for (int i = 0; i < NUM_DRIVES; i++) begin
            if (reset) begin
                waitOn[i] <= 1'b0;
                dly[i] <= 4'h0;
            end else if (insertEvent[i]) begin
                waitOn[i] <= 1'b1;
                dly[i] <= slowAns ? 4'h8 : 4'h0;
            end else if (waitOn[i]) begin
                if (dly[i] == 4'h0) begin
                    cmdPowerOn[i] <= 1'b1;
                    waitOn[i] <= 1'b0;
                end else begin
                    dly[i] <= dly[i] - 4'h1;
                end
            end
        end
    end
endmodule

// [tb_drive_hot_swap_power_ctrl.sv]
`timescale 1ns/1ns
module tb_drive_hot_swap_power_ctrl
    import dhspc_pkg::*;
;
    localparam int RETRY = 50;
    localparam int RSTC = 40;
    logic ref_clk = 1'b0, reset = 1'b1, slowAns = 1'b0;
    logic [1:0] interlockMated = '0, oc12 = '0, oc5 = '0, offReq = '0;
    logic [1:0] driveActive = '0, faultBlink = '0, faultRed = '0, faultReq = '0;
    logic fiveInTol = 1'b0, twelveAboveMin = 1'b0, system_power_good = 1'b0;
    logic [6:0] mgmtAddrStrap = 7'h10;
    logic [18:0] flashWrAddr = 19'h00000;
    logic flashWrReq = 1'b0, bootUnlock = 1'b0;
    logic [1:0] cmdPowerOn, cmdPowerOff, en12, en5, present, insertEvent, railFault;
    logic [3:0] ledColour;
    logic drive_supply_good, board_power_good, five_volt_domain_reset_n, mgmtBusConnect;
    logic [6:0] mgmtAddr;
    logic mgmtAddrOk, flashWrEn;
    logic [7:0] fruAddr;
    int errCount = 0, numChecks = 0;

    dhspc_top #(.RETRY_CYCLES(RETRY), .RST_CYCLES(RSTC), .BLINK_CYCLES(4)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .interlockMated(interlockMated),
        .cmdPowerOn(cmdPowerOn), .cmdPowerOff(cmdPowerOff), .oc12(oc12), .oc5(oc5),
        .driveActive(driveActive), .faultBlink(faultBlink), .faultRed(faultRed),
        .faultReq(faultReq), .fiveInTol(fiveInTol), .twelveAboveMin(twelveAboveMin),
        .system_power_good(system_power_good), .mgmtAddrStrap(mgmtAddrStrap),
        .flashWrAddr(flashWrAddr), .flashWrReq(flashWrReq), .bootUnlock(bootUnlock),
        .en12(en12), .en5(en5), .present(present), .insertEvent(insertEvent),
        .railFault(railFault), .ledColour(ledColour), .drive_supply_good(drive_supply_good),
        .board_power_good(board_power_good),
        .five_volt_domain_reset_n(five_volt_domain_reset_n),
        .mgmtBusConnect(mgmtBusConnect), .mgmtAddr(mgmtAddr), .mgmtAddrOk(mgmtAddrOk),
        .fruAddr(fruAddr), .flashWrEn(flashWrEn));

    dhspc_sys_model i_sys (.ref_clk(ref_clk), .reset(reset), .insertEvent(insertEvent),
        .offReq(offReq), .slowAns(slowAns), .cmdPowerOn(cmdPowerOn), .cmdPowerOff(cmdPowerOff));

    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // settle past the edge before sampling
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic printVerdict();
        $display("checks=%0d errors=%0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic t_supply();
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            {fiveInTol, twelveAboveMin, system_power_good} <= i[2:0];
            cyc(3);
            chk(drive_supply_good, i[2] & i[1]);
            chk(board_power_good, i[2] & i[0]);
            chk(mgmtBusConnect, i[0]);
        end
    endtask

    task automatic t_rst_hold();
        int n;
        @(posedge ref_clk);
        fiveInTol <= 1'b0;
        cyc(3);
        chk(five_volt_domain_reset_n, 1'b0);
        @(posedge ref_clk);
        fiveInTol <= 1'b1;
        n = 0;
        while (five_volt_domain_reset_n !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(n >= RSTC - 1 && n <= RSTC + 3, 1);
    endtask

    task automatic t_mgmt();
        logic [6:0] straps [4] = '{7'h0F, 7'h10, 7'h1F, 7'h20};
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            mgmtAddrStrap <= straps[i];
            cyc(3);
            chk(mgmtAddrOk, i == 1 || i == 2);
            if (i == 1 || i == 2) chk(mgmtAddr, straps[i]);
        end
        chk(fruAddr, FRU_ADDR);
        @(posedge ref_clk);
        flashWrReq <= 1'b1;
        flashWrAddr <= BOOT_BLOCK_BASE - 19'h1;
        cyc(3);
        chk(flashWrEn, 1'b1);
        @(posedge ref_clk);
        flashWrAddr <= BOOT_BLOCK_BASE;
        cyc(3);
        chk(flashWrEn, 1'b0);
        @(posedge ref_clk);
        bootUnlock <= 1'b1;
        cyc(3);
        chk(flashWrEn, 1'b1);
        @(posedge ref_clk);
        flashWrReq <= 1'b0;
        bootUnlock <= 1'b0;
        cyc(3);
        chk(flashWrEn, 1'b0);
    endtask

    task automatic t_insert_oc();
        int n;
        @(posedge ref_clk);
        slowAns <= 1'b1;
        interlockMated <= 2'b01;
        n = 0;
        while (insertEvent[0] !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        chk(n < 20, 1);
        cyc(2);
        chk(present, 2'b01);
        chk({en12, en5}, 4'h0);
        n = 0;
        while (en5[0] !== 1'b1 && n < 30) begin
            cyc(1);
            n++;
        end
        chk({en12[0], en5[0]}, 2'b11);
        @(posedge ref_clk);
        oc5[0] <= 1'b1;
        cyc(20);
        chk(en5[0], 1'b1);
        n = 0;
        while (en5[0] !== 1'b0 && n < 40) begin
            cyc(1);
            n++;
        end
        chk(n + 21 >= 30 && n + 21 <= 36, 1);
        chk({en12[0], railFault[0]}, 2'b11);
        n = 0;
        while (en5[0] !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(n >= RETRY - 2 && n <= RETRY + 3, 1);
        @(posedge ref_clk);
        oc5[0] <= 1'b0;
        cyc(40);
        chk({en5[0], railFault[0]}, 2'b10);
    endtask

    task automatic t_off_stagger();
        int n;
        @(posedge ref_clk);
        offReq <= 2'b01;
        @(posedge ref_clk);
        offReq <= 2'b00;
        cyc(4);
        chk({en12[0], en5[0], present[0]}, 3'b001);
        @(posedge ref_clk);
        interlockMated <= 2'b00;
        slowAns <= 1'b0;
        cyc(2 * RETRY);
        @(posedge ref_clk);
        interlockMated <= 2'b11;
        n = 0;
        while (en12[0] !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk({en12, en5}, 4'h5);
        n = 0;
        while (en12[1] !== 1'b1 && n < 200) begin
            cyc(1);
            n++;
        end
        chk(n >= RETRY - 2 && n <= RETRY + 2, 1);
        @(posedge ref_clk);
        offReq <= 2'b11;
        @(posedge ref_clk);
        offReq <= 2'b00;
        cyc(4);
        chk({en12, en5}, 4'h0);
    endtask

    task automatic t_led();
        int k;
        @(posedge ref_clk);
        driveActive <= 2'b01;
        faultReq <= 2'b10;
        faultRed <= 2'b10;
        cyc(4);
        chk(ledColour, {LED_RED, LED_GREEN});
        @(posedge ref_clk);
        faultRed <= 2'b00;
        cyc(4);
        chk(ledColour[3:2], LED_YELLOW);
        @(posedge ref_clk);
        faultBlink <= 2'b10;
        k = 0;
        for (int i = 0; i < 16; i++) begin
            cyc(1);
            if (ledColour[3:2] === LED_OFF) k++;
        end
        chk(k > 0 && k < 16, 1);
    endtask

    initial begin
        #(20 * 6000);
        errCount++;
        printVerdict();
    end

    initial begin
        cyc(11);
        chk({en12, en5, mgmtBusConnect, five_volt_domain_reset_n}, 6'h00);
        chk({mgmtAddr, fruAddr}, {7'h10, 8'hA0});
        @(posedge ref_clk);
        reset <= 1'b0;
        cyc(2);
        t_supply();
        t_rst_hold();
        t_mgmt();
        t_insert_oc();
        t_off_stagger();
        t_led();
        printVerdict();
    end
endmodule
